//--- rtl/cfg_loader_pkg.sv
package cfg_loader_pkg;

  // Configuration memory word addresses
  localparam logic [7:0] WORD_PHY2 = 8'h1c;
  localparam logic [7:0] WORD_PORT0 = 8'h20;
  localparam logic [7:0] WORD_PORT1 = 8'h22;
  localparam logic [7:0] WORD_PORT2 = 8'h24;

  // Source bit positions inside a loaded word
  localparam int SRC_SLOT_IMPL = 0;
  localparam int SRC_SLOT_CLK = 1;
  localparam int SRC_DSI = 2;
  localparam int SRC_PNUM_LO = 4;
  localparam int SRC_SCALE_LO = 6;
  localparam int SRC_TC_LO = 9;
  localparam int SRC_RXDET_LO = 4;

  // Field widths
  localparam int PNUM_W = 2;
  localparam int SCALE_W = 2;
  localparam int TC_W = 7;
  localparam int RXDET_W = 3;

  // Destination configuration-space offsets and bit positions
  localparam logic [11:0] CFG_PHY2_OFS = 12'h0bc;
  localparam int DST_RXDET_LO = 4;
  localparam logic [11:0] CFG_SLOT_CLK_OFS = 12'h0f0;
  localparam int DST_SLOT_CLK = 28;
  localparam logic [11:0] CFG_DSI_OFS = 12'h080;
  localparam int DST_DSI = 21;
  localparam logic [11:0] CFG_PNUM_OFS = 12'h0ec;
  localparam int DST_PNUM_LO = 24;
  localparam logic [11:0] CFG_SCALE_OFS = 12'h084;
  localparam int DST_SCALE_LO = 13;
  localparam logic [11:0] CFG_TC_OFS = 12'h154;
  localparam int DST_TC_LO = 1;
  localparam logic [11:0] CFG_SLOT_IMPL_OFS = 12'h0e0;
  localparam int DST_SLOT_IMPL = 24;

  // AXI4-Lite register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PHY2 = 8'h08;
  localparam logic [7:0] REG_PORT0 = 8'h10;
  localparam logic [7:0] REG_PORT1 = 8'h14;
  localparam logic [7:0] REG_PORT2 = 8'h18;

  // Control and status bit positions
  localparam int CTRL_LOAD_EN = 0;
  localparam int CTRL_RELOAD = 1;
  localparam int STAT_READY = 0;
  localparam int STAT_SEEN_LO = 1;
  localparam int STAT_REFUSED = 5;

  // Reset values
  localparam logic LOAD_EN_RST = 1'b1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : cfg_loader_pkg

//--- rtl/port_field_slice.sv
`timescale 1ns/1ns
`default_nettype none
module port_field_slice
  import cfg_loader_pkg::*;
#(
  parameter logic [7:0] WORD_ADDR = 8'h20,
  parameter bit HAS_SLOT = 1'b0,
  parameter bit HAS_EXT = 1'b1
)
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] data_i,
  output logic slot_impl_o,
  output logic slot_clock_o,
  output logic dsi_o,
  output logic [PNUM_W-1:0] port_num_o,
  output logic [SCALE_W-1:0] pm_scale_o,
  output logic [TC_W-1:0] tc_map_o
);

  logic slot_impl_d;
  logic slot_clock_d;
  logic dsi_d;
  logic [PNUM_W-1:0] port_num_d;
  logic [SCALE_W-1:0] pm_scale_d;
  logic [TC_W-1:0] tc_map_d;

  always_comb
  begin
    slot_impl_d = slot_impl_o;
    slot_clock_d = slot_clock_o;
    dsi_d = dsi_o;
    port_num_d = port_num_o;
    pm_scale_d = pm_scale_o;
    tc_map_d = tc_map_o;
    if (load_i && addr_i == WORD_ADDR)
    begin
      if (HAS_SLOT)
      begin
        slot_impl_d = data_i[SRC_SLOT_IMPL];
      end
      slot_clock_d = data_i[SRC_SLOT_CLK];
      dsi_d = data_i[SRC_DSI];
      if (HAS_EXT)
      begin
        port_num_d = data_i[SRC_PNUM_LO +: PNUM_W];
        pm_scale_d = data_i[SRC_SCALE_LO +: SCALE_W];
        tc_map_d = data_i[SRC_TC_LO +: TC_W];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      slot_impl_o <= 1'b0;
      slot_clock_o <= 1'b0;
      dsi_o <= 1'b0;
      port_num_o <= '0;
      pm_scale_o <= '0;
      tc_map_o <= '0;
    end
    else
    begin
      slot_impl_o <= slot_impl_d;
      slot_clock_o <= slot_clock_d;
      dsi_o <= dsi_d;
      port_num_o <= port_num_d;
      pm_scale_o <= pm_scale_d;
      tc_map_o <= tc_map_d;
    end
  end

endmodule : port_field_slice
`default_nettype wire

//--- rtl/eeprom_port_config_loader.sv
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module eeprom_port_config_loader
  import cfg_loader_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  // Words delivered by the configuration memory reader
  input wire logic word_valid_i,
  input wire logic [7:0] word_addr_i,
  input wire logic [15:0] word_data_i,
  input wire logic load_done_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Loaded configuration fields
  output logic [RXDET_W-1:0] rx_detect_threshold_o,
  output logic [2:0] slot_implemented_o,
  output logic [2:0] reference_clock_input_o,
  output logic [2:0] dsi_required_o,
  output logic [3*PNUM_W-1:0] port_number_o,
  output logic [3*SCALE_W-1:0] pm_data_scale_o,
  output logic [3*TC_W-1:0] tc_vc0_map_o,
  output logic config_ready_o,
  output logic reload_request_o
);

  logic load_en_q;
  logic load_en_d;
  logic reload_q;
  logic reload_d;
  logic ready_q;
  logic ready_d;
  logic [3:0] seen_q;
  logic [3:0] seen_d;
  logic refused_q;
  logic refused_d;
  logic [RXDET_W-1:0] rxdet_q;
  logic [RXDET_W-1:0] rxdet_d;
  logic word_load;

  logic aw_have_q;
  logic aw_have_d;
  logic w_have_q;
  logic w_have_d;
  logic [7:0] awaddr_q;
  logic [7:0] awaddr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0] wstrb_q;
  logic [3:0] wstrb_d;
  logic awready_d;
  logic wready_d;
  logic bvalid_d;
  logic [1:0] bresp_d;
  logic arready_d;
  logic rvalid_d;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;
  logic wr_fire;
  logic wr_mapped;
  logic [31:0] rd_word;
  logic rd_mapped;

  // Words are applied only while loading is enabled and before release
  assign word_load = word_valid_i && load_en_q && !ready_q;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  port_field_slice #(
    .WORD_ADDR(WORD_PORT0),
    .HAS_SLOT(1'b0),
    .HAS_EXT(1'b1)
  ) u_port0 (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .load_i(word_load),
    .addr_i(word_addr_i),
    .data_i(word_data_i),
    .slot_impl_o(slot_implemented_o[0]),
    .slot_clock_o(reference_clock_input_o[0]),
    .dsi_o(dsi_required_o[0]),
    .port_num_o(port_number_o[0 +: PNUM_W]),
    .pm_scale_o(pm_data_scale_o[0 +: SCALE_W]),
    .tc_map_o(tc_vc0_map_o[0 +: TC_W])
  );

  port_field_slice #(
    .WORD_ADDR(WORD_PORT1),
    .HAS_SLOT(1'b1),
    .HAS_EXT(1'b1)
  ) u_port1 (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .load_i(word_load),
    .addr_i(word_addr_i),
    .data_i(word_data_i),
    .slot_impl_o(slot_implemented_o[1]),
    .slot_clock_o(reference_clock_input_o[1]),
    .dsi_o(dsi_required_o[1]),
    .port_num_o(port_number_o[PNUM_W +: PNUM_W]),
    .pm_scale_o(pm_data_scale_o[SCALE_W +: SCALE_W]),
    .tc_map_o(tc_vc0_map_o[TC_W +: TC_W])
  );

  port_field_slice #(
    .WORD_ADDR(WORD_PORT2),
    .HAS_SLOT(1'b1),
    .HAS_EXT(1'b0)
  ) u_port2 (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .load_i(word_load),
    .addr_i(word_addr_i),
    .data_i(word_data_i),
    .slot_impl_o(slot_implemented_o[2]),
    .slot_clock_o(reference_clock_input_o[2]),
    .dsi_o(dsi_required_o[2]),
    .port_num_o(port_number_o[2*PNUM_W +: PNUM_W]),
    .pm_scale_o(pm_data_scale_o[2*SCALE_W +: SCALE_W]),
    .tc_map_o(tc_vc0_map_o[2*TC_W +: TC_W])
  );

  // Register write decode
  always_comb
  begin
    case (awaddr_q)
      REG_CTRL, REG_STATUS: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // Loader and control state
  always_comb
  begin
    load_en_d = load_en_q;
    reload_d = 1'b0;
    ready_d = ready_q;
    seen_d = seen_q;
    refused_d = refused_q;
    rxdet_d = rxdet_q;
    if (wr_fire && wstrb_q[0] && awaddr_q == REG_CTRL)
    begin
      load_en_d = wdata_q[CTRL_LOAD_EN];
      if (wdata_q[CTRL_RELOAD])
      begin
        reload_d = 1'b1;
        ready_d = 1'b0;
        seen_d = '0;
      end
    end
    if (wr_fire && wstrb_q[0] && awaddr_q == REG_STATUS &&
        wdata_q[STAT_REFUSED])
    begin
      refused_d = 1'b0;
    end
    // One shared word sets the threshold for every port
    if (word_load && word_addr_i == WORD_PHY2)
    begin
      rxdet_d = word_data_i[SRC_RXDET_LO +: RXDET_W];
    end
    if (word_load)
    begin
      case (word_addr_i)
        WORD_PHY2: seen_d[0] = 1'b1;
        WORD_PORT0: seen_d[1] = 1'b1;
        WORD_PORT1: seen_d[2] = 1'b1;
        WORD_PORT2: seen_d[3] = 1'b1;
        default: seen_d = seen_d;
      endcase
    end
    // Words after release are not applied; set wins over clear
    if (word_valid_i && (ready_q || !load_en_q))
    begin
      refused_d = 1'b1;
    end
    // Fields land on the same edge, so release never precedes them
    if (load_done_i && load_en_q)
    begin
      ready_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      load_en_q <= LOAD_EN_RST;
      reload_q <= 1'b0;
      ready_q <= 1'b0;
      seen_q <= '0;
      refused_q <= 1'b0;
      rxdet_q <= '0;
    end
    else
    begin
      load_en_q <= load_en_d;
      reload_q <= reload_d;
      ready_q <= ready_d;
      seen_q <= seen_d;
      refused_q <= refused_d;
      rxdet_q <= rxdet_d;
    end
  end

  assign config_ready_o = ready_q;
  assign reload_request_o = reload_q;
  assign rx_detect_threshold_o = rxdet_q;

  // Register read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      REG_CTRL: rd_word[CTRL_LOAD_EN] = load_en_q;
      REG_STATUS:
      begin
        rd_word[STAT_READY] = ready_q;
        rd_word[STAT_SEEN_LO +: 4] = seen_q;
        rd_word[STAT_REFUSED] = refused_q;
      end
      REG_PHY2: rd_word[SRC_RXDET_LO +: RXDET_W] = rxdet_q;
      REG_PORT0, REG_PORT1, REG_PORT2:
      begin
        int p;
        p = (s_axi_araddr == REG_PORT0) ? 0 :
            (s_axi_araddr == REG_PORT1) ? 1 : 2;
        rd_word[SRC_SLOT_IMPL] = slot_implemented_o[p];
        rd_word[SRC_SLOT_CLK] = reference_clock_input_o[p];
        rd_word[SRC_DSI] = dsi_required_o[p];
        rd_word[SRC_PNUM_LO +: PNUM_W] = port_number_o[p*PNUM_W +: PNUM_W];
        rd_word[SRC_SCALE_LO +: SCALE_W] =
          pm_data_scale_o[p*SCALE_W +: SCALE_W];
        rd_word[SRC_TC_LO +: TC_W] = tc_vc0_map_o[p*TC_W +: TC_W];
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  // AXI4-Lite channel state
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    arready_d = s_axi_arready;
    rvalid_d = s_axi_rvalid;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    if (s_axi_arvalid && s_axi_arready)
    begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = rd_word;
      rresp_d = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end
  end

endmodule : eeprom_port_config_loader
`default_nettype wire

//--- tb/loader_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module loader_monitor
  import cfg_loader_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic word_valid_i,
  input wire logic [7:0] word_addr_i,
  input wire logic [15:0] word_data_i,
  input wire logic load_done_i,
  input wire logic [RXDET_W-1:0] rx_detect_threshold_o,
  input wire logic [2:0] slot_implemented_o,
  input wire logic [2:0] reference_clock_input_o,
  input wire logic [2:0] dsi_required_o,
  input wire logic [3*PNUM_W-1:0] port_number_o,
  input wire logic [3*SCALE_W-1:0] pm_data_scale_o,
  input wire logic [3*TC_W-1:0] tc_vc0_map_o,
  input wire logic config_ready_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic [44:0] all_f;
  assign all_f = {rx_detect_threshold_o, slot_implemented_o,
    reference_clock_input_o, dsi_required_o, port_number_o,
    pm_data_scale_o, tc_vc0_map_o};
  AST_RXDET: assert property (
    $changed(rx_detect_threshold_o) |-> $past(word_valid_i &&
    word_addr_i == WORD_PHY2) && rx_detect_threshold_o ==
    $past(word_data_i[6:4])) else $error("threshold load wrong");
  AST_P0_CLK_DSI: assert property (
    $changed({reference_clock_input_o[0], dsi_required_o[0]}) |->
    $past(word_valid_i && word_addr_i == WORD_PORT0) &&
    {reference_clock_input_o[0], dsi_required_o[0]} ==
    $past({word_data_i[1], word_data_i[2]})) else $error("p0 clk dsi");
  AST_P0_NUM_SCALE: assert property (
    $changed({port_number_o[1:0], pm_data_scale_o[1:0]}) |->
    $past(word_valid_i && word_addr_i == WORD_PORT0) &&
    {port_number_o[1:0], pm_data_scale_o[1:0]} ==
    $past({word_data_i[5:4], word_data_i[7:6]})) else $error("p0 num");
  AST_P0_TC: assert property (
    $changed(tc_vc0_map_o[6:0]) |-> $past(word_valid_i &&
    word_addr_i == WORD_PORT0) && tc_vc0_map_o[6:0] ==
    $past(word_data_i[15:9])) else $error("p0 tc map");
  AST_P1_BITS: assert property (
    $changed({slot_implemented_o[1], reference_clock_input_o[1],
    dsi_required_o[1]}) |-> $past(word_valid_i && word_addr_i ==
    WORD_PORT1) && {slot_implemented_o[1], reference_clock_input_o[1],
    dsi_required_o[1]} == $past({word_data_i[0], word_data_i[1],
    word_data_i[2]})) else $error("p1 bits");
  AST_P1_FIELDS: assert property (
    $changed({port_number_o[3:2], pm_data_scale_o[3:2],
    tc_vc0_map_o[13:7]}) |-> $past(word_valid_i && word_addr_i ==
    WORD_PORT1) && {port_number_o[3:2], pm_data_scale_o[3:2],
    tc_vc0_map_o[13:7]} == $past({word_data_i[5:4], word_data_i[7:6],
    word_data_i[15:9]})) else $error("p1 fields");
  AST_P2_BITS: assert property (
    $changed({slot_implemented_o[2], reference_clock_input_o[2],
    dsi_required_o[2]}) |-> $past(word_valid_i && word_addr_i ==
    WORD_PORT2) && {slot_implemented_o[2], reference_clock_input_o[2],
    dsi_required_o[2]} == $past({word_data_i[0], word_data_i[1],
    word_data_i[2]})) else $error("p2 bits");
  AST_READY_RISE: assert property (
    $rose(config_ready_o) |-> $past(load_done_i))
    else $error("ready without done");
  AST_FROZEN: assert property (
    $past(config_ready_o) |-> $stable(all_f))
    else $error("field changed while ready");
endmodule : loader_monitor
bind eeprom_port_config_loader loader_monitor mon (.mclk_i, .reset_i,
  .word_valid_i, .word_addr_i, .word_data_i, .load_done_i,
  .rx_detect_threshold_o, .slot_implemented_o, .reference_clock_input_o,
  .dsi_required_o, .port_number_o, .pm_data_scale_o, .tc_vc0_map_o,
  .config_ready_o);
`default_nettype wire

//--- tb/cfg_memory_model.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_memory_model
  import cfg_loader_pkg::*;
(
  input wire logic mclk_i,
  output logic word_valid_o,
  output logic [7:0] word_addr_o,
  output logic [15:0] word_data_o,
  output logic load_done_o
);
  // Word order of the memory image
  localparam logic [7:0] ADDRS [4] = '{WORD_PHY2, WORD_PORT0, WORD_PORT1,
    WORD_PORT2};
  initial
  begin
    word_valid_o = 1'b0;
    word_addr_o = 8'h00;
    word_data_o = 16'h0000;
    load_done_o = 1'b0;
  end
  task automatic put(input logic v, input logic [7:0] a,
    input logic [15:0] d, input logic done);
    word_valid_o <= v;
    word_addr_o <= a;
    word_data_o <= d;
    load_done_o <= done;
    @(posedge mclk_i);
  endtask : put
  // Released lines toggle so stale data never looks valid
  task automatic idle(input int n);
    repeat (n) put(1'b0, ~word_addr_o, ~word_data_o, 1'b0);
  endtask : idle
  task automatic stream(input logic [15:0] w [4], input int gap);
    for (int i = 0; i < 4; i++)
    begin
      put(1'b1, ADDRS[i], w[i], 1'b0);
      idle(gap);
    end
    put(1'b0, ~word_addr_o, ~word_data_o, 1'b1);
    idle(1);
  endtask : stream
endmodule : cfg_memory_model
`default_nettype wire

//--- tb/eeprom_port_config_loader_tb.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_port_config_loader_tb
  import cfg_loader_pkg::*;
;
  logic mclk_i, reset_i, wv, wdone, awvalid, wvalid, bready, arvalid;
  logic rready, awready, wready, bvalid, arready, rvalid, rdy, rld;
  logic [7:0] wa, awaddr, araddr;
  logic [15:0] wd;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, r;
  logic [2:0] rx, slot, rclk, dsi;
  logic [5:0] pn, pm;
  logic [20:0] tc;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int reloads = 0;
  logic [15:0] pa [4] = '{16'h0050, 16'h5a96, 16'ha569, 16'h0005};
  logic [15:0] pb [4] = '{16'hffaf, 16'ha569, 16'h5a96, 16'hfffa};
  eeprom_port_config_loader dut (.mclk_i(mclk_i), .reset_i(reset_i),
    .word_valid_i(wv), .word_addr_i(wa), .word_data_i(wd),
    .load_done_i(wdone), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_detect_threshold_o(rx), .slot_implemented_o(slot),
    .reference_clock_input_o(rclk), .dsi_required_o(dsi),
    .port_number_o(pn), .pm_data_scale_o(pm), .tc_vc0_map_o(tc),
    .config_ready_o(rdy), .reload_request_o(rld));
  cfg_memory_model mem (.mclk_i(mclk_i), .word_valid_o(wv),
    .word_addr_o(wa), .word_data_o(wd), .load_done_o(wdone));
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic end_of_test;
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  // Counts cycles with the reload pulse high
  always @(posedge mclk_i)
  begin
    if (rld === 1'b1)
      reloads <= reloads + 1;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge mclk_i);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge mclk_i);
  endtask : axw
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge mclk_i);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        chk("rdata", rdata, e);
        chk("rresp", rresp, er);
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge mclk_i);
  endtask : rchk
  task automatic cf(input logic [15:0] w [4]);
    chk("rx_threshold", rx, w[0][6:4]);
    chk("p0_clock", rclk[0], w[1][1]);
    chk("p0_dsi", dsi[0], w[1][2]);
    chk("p0_number", pn[1:0], w[1][5:4]);
    chk("p0_scale", pm[1:0], w[1][7:6]);
    chk("p0_tc", tc[6:0], w[1][15:9]);
    chk("p1_slot", slot[1], w[2][0]);
    chk("p1_clock", rclk[1], w[2][1]);
    chk("p1_dsi", dsi[1], w[2][2]);
    chk("p1_number", pn[3:2], w[2][5:4]);
    chk("p1_scale", pm[3:2], w[2][7:6]);
    chk("p1_tc", tc[13:7], w[2][15:9]);
    chk("p2_slot", slot[2], w[3][0]);
    chk("p2_clock", rclk[2], w[3][1]);
    chk("p2_dsi", dsi[2], w[3][2]);
    chk("unused", {slot[0], pn[5:4], pm[5:4], tc[20:14]}, 32'h0);
  endtask : cf
  task automatic t_reset;
    chk("fields", {rx, slot, rclk, dsi, pn, pm}, 32'h0);
    chk("tc", tc, 32'h0);
    chk("ready", rdy, 1'b0);
    chk("reload", rld, 1'b0);
    rchk(REG_CTRL, 32'h1, RESP_OKAY);
  endtask : t_reset
  // Word after loading completes is refused and leaves fields alone
  task automatic t_refuse;
    mem.put(1'b1, WORD_PORT0, ~pa[1], 1'b0);
    mem.idle(1);
    cf(pa);
    rchk(REG_PHY2, {25'h0, pa[0][6:4], 4'h0}, RESP_OKAY);
    rchk(REG_PORT0, {16'h0, pa[1] & 16'hfef6}, RESP_OKAY);
    rchk(REG_PORT1, {16'h0, pa[2] & 16'hfef7}, RESP_OKAY);
    rchk(REG_PORT2, {16'h0, pa[3] & 16'h0007}, RESP_OKAY);
    rchk(REG_STATUS, 32'h3f, RESP_OKAY);
    axw(REG_STATUS, 32'h20);
    rchk(REG_STATUS, 32'h1f, RESP_OKAY);
    rchk(8'h0c, 32'h0, RESP_SLVERR);
    axw(8'h40, 32'h1);
    chk("bresp", r, RESP_SLVERR);
  endtask : t_refuse
  task automatic t_reload;
    axw(REG_CTRL, 32'h3);
    chk("ready", rdy, 1'b0);
    chk("reloads", reloads, 32'h1);
    rchk(REG_STATUS, 32'h0, RESP_OKAY);
    mem.stream(pb, 3);
    cf(pb);
    chk("ready", rdy, 1'b1);
  endtask : t_reload
  // Loading disabled: words and done are ignored until re-enabled
  task automatic t_disabled;
    axw(REG_CTRL, 32'h2);
    chk("reloads", reloads, 32'h2);
    mem.stream(pa, 0);
    cf(pb);
    chk("ready", rdy, 1'b0);
    rchk(REG_STATUS, 32'h20, RESP_OKAY);
    axw(REG_CTRL, 32'h1);
    mem.put(1'b0, 8'h00, 16'h0000, 1'b1);
    mem.idle(1);
    chk("ready", rdy, 1'b1);
    cf(pb);
    chk("reloads", reloads, 32'h2);
  endtask : t_disabled
  initial
  begin
    reset_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    t_reset();
    mem.stream(pa, 0);
    cf(pa);
    chk("ready", rdy, 1'b1);
    t_refuse();
    t_reload();
    t_disabled();
    end_of_test();
  end
endmodule : eeprom_port_config_loader_tb
`default_nettype wire
